// *** core/ump_pins.sv ***
`timescale 1ns/1ns
module ump_pins
  import ump_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic hard_clear_in,
  // host bus
  input wire logic [ump_pkg::ADDR_W-1:0] addr_in,
  input wire logic select_a_hi_in,
  input wire logic select_b_hi_in,
  input wire logic select_c_lo_in,
  input wire logic addr_latch_strobe_n_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [ump_pkg::DATA_W-1:0] data_in,
  output logic [ump_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic xcvr_off_n_out,
  // interrupt sources and enables
  input wire logic msi_enable_in,
  input wire logic rx_error_in,
  input wire logic rx_avail_in,
  input wire logic rx_timeout_in,
  input wire logic fifo_mode_in,
  input wire logic thr_empty_in,
  output logic irq_out,
  // flow control
  input wire logic rx_threshold_hit_in,
  output logic tx_gate_out,
  // modem lines, active low
  input wire logic cts_n_in,
  input wire logic dsr_n_in,
  input wire logic ri_n_in,
  input wire logic dcd_n_in,
  output logic dtr_n_out,
  output logic rts_n_out,
  output logic user_pin_a_n_out,
  output logic user_pin_b_n_out
);
  import ump_pkg::*;

  typedef struct packed {
    logic [MCR_W-1:0] modem_ctrl_reg;
    logic [LINES-1:0] lvl;
    logic [LINES-1:0] delta;
    logic msr_rd;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic tx_gate;
    logic [3:0] pins_n;
  } ump_state_t;

  ump_state_t st;
  ump_state_t next_st;
  logic [1:0] rst_sync;
  logic rst_sync_n;
  logic reading;
  logic msr_rd_now;
  logic mcr_wr_now;
  logic [LINES-1:0] lvl_now;
  logic [LINES-1:0] chg;
  logic msi_pend;
  logic loop_mode;
  logic auto_mode;

  ump_sel_if sel ();

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
    hit = sel.selected && (a == t);
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync[1];

  ump_select_latch u_sel (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_sync_n),
    .addr_in(addr_in),
    .select_a_hi_in(select_a_hi_in),
    .select_b_hi_in(select_b_hi_in),
    .select_c_lo_in(select_c_lo_in),
    .addr_latch_strobe_n_in(addr_latch_strobe_n_in),
    .sel(sel)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  assign reading = sel.selected && rd_in;
  assign msr_rd_now = reading && hit(sel.addr, ADDR_MSR);
  assign mcr_wr_now = wr_in && !rd_in && hit(sel.addr, ADDR_MCR);
  assign loop_mode = st.modem_ctrl_reg[MCR_LOOP];
  assign auto_mode = st.modem_ctrl_reg[MCR_AUTO];

  // loop mode feeds the control bits back as modem line levels
  always_comb begin
    if (loop_mode) begin
      lvl_now[LN_CTS] = st.modem_ctrl_reg[MCR_RTS];
      lvl_now[LN_DSR] = st.modem_ctrl_reg[MCR_DTR];
      lvl_now[LN_RI] = st.modem_ctrl_reg[MCR_OUT_A];
      lvl_now[LN_DCD] = st.modem_ctrl_reg[MCR_OUT_B];
    end else begin
      lvl_now = ~{dcd_n_in, ri_n_in, dsr_n_in, cts_n_in};
    end
  end

  // ri reports only the trailing edge of a ring
  always_comb begin
    chg = lvl_now ^ st.lvl;
    chg[LN_RI] = st.lvl[LN_RI] && !lvl_now[LN_RI];
  end

  // auto flow masks the cts change from the interrupt only, not the flag
  assign msi_pend = msi_enable_in && ((st.delta[LN_CTS] && !auto_mode)
    || st.delta[LN_DSR] || st.delta[LN_RI] || st.delta[LN_DCD]);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.lvl = lvl_now;
    next_st.msr_rd = msr_rd_now;
    if (mcr_wr_now) begin
      next_st.modem_ctrl_reg = data_in[MCR_W-1:0];
    end
    // clear at the end of the read so the host sees the flags first;
    // a change in the same cycle survives the clear
    if (st.msr_rd && !msr_rd_now) begin
      next_st.delta = chg;
    end else begin
      next_st.delta = st.delta | chg;
    end
    if (msr_rd_now) begin
      next_st.rdata = {st.lvl, st.delta};
    end else if (reading && hit(sel.addr, ADDR_MCR)) begin
      next_st.rdata = {{(DATA_W-MCR_W){1'b0}}, st.modem_ctrl_reg};
    end else begin
      next_st.rdata = '0;
    end
    next_st.irq = rx_error_in || rx_avail_in || (fifo_mode_in && rx_timeout_in)
      || thr_empty_in || msi_pend;
    next_st.tx_gate = !auto_mode || lvl_now[LN_CTS];
    if (loop_mode) begin
      next_st.pins_n = PINS_IDLE_N;
    end else begin
      next_st.pins_n[0] = !st.modem_ctrl_reg[MCR_DTR];
      next_st.pins_n[1] = !(st.modem_ctrl_reg[MCR_RTS]
        && !(auto_mode && rx_threshold_hit_in));
      next_st.pins_n[2] = !st.modem_ctrl_reg[MCR_OUT_A];
      next_st.pins_n[3] = !st.modem_ctrl_reg[MCR_OUT_B];
    end
    if (hard_clear_in) begin
      next_st.modem_ctrl_reg = MCR_RESET;
      next_st.delta = DELTA_NONE;
      next_st.irq = 1'b0;
      next_st.pins_n = PINS_IDLE_N;
      next_st.rdata = '0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '{modem_ctrl_reg: MCR_RESET, lvl: '0, delta: DELTA_NONE, msr_rd: 1'b0,
        rdata: '0, irq: 1'b0, tx_gate: 1'b1, pins_n: PINS_IDLE_N};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign data_out = st.rdata;
  assign data_oe_out = reading;
  assign xcvr_off_n_out = reading;
  assign irq_out = st.irq;
  assign tx_gate_out = st.tx_gate;
  assign dtr_n_out = st.pins_n[0];
  assign rts_n_out = st.pins_n[1];
  assign user_pin_a_n_out = st.pins_n[2];
  assign user_pin_b_n_out = st.pins_n[3];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_sync_n);

  sequence s_msr_read;
    msr_rd_now && !hard_clear_in;
  endsequence

  sequence s_read_end;
    st.msr_rd && !msr_rd_now && (chg == DELTA_NONE) && !hard_clear_in;
  endsequence

  a_bus_idle_deselect: assert property (!sel.selected |-> !data_oe_out)
    else $error("data bus driven while deselected");
  a_xcvr_off_idle: assert property (!rd_in |-> !xcvr_off_n_out && !data_oe_out)
    else $error("transceiver enabled without a read");
  a_msr_level_read: assert property (s_msr_read
    |=> data_out[DATA_W-1:MSR_LVL_LSB] == $past(st.lvl)
    && data_out[MSR_LVL_LSB-1:0] == $past(st.delta))
    else $error("status read returned wrong bits");
  a_cts_delta_set: assert property (!hard_clear_in && chg[LN_CTS]
    |=> st.delta[LN_CTS])
    else $error("cts change not flagged");
  a_dcd_delta_set: assert property (!hard_clear_in && chg[LN_DCD]
    |=> st.delta[LN_DCD])
    else $error("carrier detect change not flagged");
  a_ri_trailing_edge: assert property (!hard_clear_in && !loop_mode
    && !$past(loop_mode) && !$past(ri_n_in) && ri_n_in && $past(rst_sync_n)
    |=> st.delta[LN_RI])
    else $error("ring trailing edge not flagged");
  a_msr_read_clear: assert property (s_read_end
    |=> st.delta == DELTA_NONE ##1 (!irq_out || $past(rx_error_in || rx_avail_in
    || (fifo_mode_in && rx_timeout_in) || thr_empty_in)))
    else $error("status read did not clear deltas");
  a_cts_no_irq_auto: assert property (auto_mode && st.delta == (4'h1 << LN_CTS)
    && !rx_error_in && !rx_avail_in && !rx_timeout_in && !thr_empty_in |=> !irq_out)
    else $error("cts change interrupted in auto mode");
  a_dsr_irq_raise: assert property (msi_enable_in && !hard_clear_in
    && (st.delta[LN_DSR] || st.delta[LN_DCD]) |=> irq_out)
    else $error("dsr or dcd change did not interrupt");
  a_ri_irq_raise: assert property (msi_enable_in && st.delta[LN_RI] && !hard_clear_in
    |=> irq_out)
    else $error("ring edge did not interrupt");
  a_tx_gate_cts: assert property (auto_mode && !loop_mode && cts_n_in
    && !hard_clear_in |=> !tx_gate_out)
    else $error("transmitter not gated by cts");
  a_tx_gate_open: assert property (!auto_mode |=> tx_gate_out)
    else $error("transmitter gated without auto flow");

  // ****************************************************************
  // checks: output pins, interrupt and host bus
  // ****************************************************************
  sequence s_pins_follow;
    !loop_mode && !hard_clear_in;
  endsequence

  a_loop_pins_idle: assert property (loop_mode && !mcr_wr_now
    |=> dtr_n_out && rts_n_out && user_pin_a_n_out && user_pin_b_n_out)
    else $error("modem outputs active in loop mode");
  a_dtr_follow_bit: assert property (s_pins_follow
    |=> dtr_n_out == !$past(st.modem_ctrl_reg[MCR_DTR]))
    else $error("terminal ready pin does not follow its bit");
  a_user_a_follow: assert property (s_pins_follow
    |=> user_pin_a_n_out == !$past(st.modem_ctrl_reg[MCR_OUT_A]))
    else $error("user pin a does not follow its bit");
  a_user_b_follow: assert property (s_pins_follow
    |=> user_pin_b_n_out == !$past(st.modem_ctrl_reg[MCR_OUT_B]))
    else $error("user pin b does not follow its bit");
  a_rts_manual: assert property (s_pins_follow && !auto_mode
    |=> rts_n_out == !$past(st.modem_ctrl_reg[MCR_RTS]))
    else $error("request to send does not follow its bit");
  a_rts_auto_off: assert property (auto_mode && rx_threshold_hit_in && !hard_clear_in
    |=> rts_n_out)
    else $error("request to send active above receive threshold");
  a_hard_clear_out: assert property (hard_clear_in
    |=> !irq_out && dtr_n_out && rts_n_out && st.modem_ctrl_reg == MCR_RESET)
    else $error("hard clear left state active");
  a_irq_source_up: assert property ((rx_error_in || rx_avail_in || thr_empty_in
    || (fifo_mode_in && rx_timeout_in)) && !hard_clear_in |=> irq_out)
    else $error("interrupt source did not raise the interrupt");
  a_timeout_no_fifo: assert property (!fifo_mode_in && !rx_error_in && !rx_avail_in
    && !thr_empty_in && !msi_pend |=> !irq_out)
    else $error("interrupt raised without a live source");
  a_read_drives_bus: assert property (sel.selected && rd_in
    |-> data_oe_out && xcvr_off_n_out)
    else $error("selected read left the bus undriven");
  a_deselect_no_write: assert property (!sel.selected && !hard_clear_in
    |=> $stable(st.modem_ctrl_reg))
    else $error("control bits written while deselected");

endmodule // ump_pins

// *** core/ump_pkg.sv ***
package ump_pkg;

  // ****************************************************************
  // host bus
  // ****************************************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_MSR = 3'h6;

  // ****************************************************************
  // modem control bits
  // ****************************************************************
  localparam int MCR_W = 6;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT_A = 2;
  localparam int MCR_OUT_B = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_AUTO = 5;
  localparam logic [5:0] MCR_RESET = 6'h00;

  // ****************************************************************
  // modem status bits; line index 0 cts, 1 dsr, 2 ri, 3 dcd
  // ****************************************************************
  localparam int LINES = 4;
  localparam int LN_CTS = 0;
  localparam int LN_DSR = 1;
  localparam int LN_RI = 2;
  localparam int LN_DCD = 3;
  localparam int MSR_LVL_LSB = 4;
  localparam logic [3:0] DELTA_NONE = 4'h0;
  localparam logic [3:0] PINS_IDLE_N = 4'hf;

endpackage

// *** core/ump_sel_if.sv ***
`timescale 1ns/1ns
interface ump_sel_if;
  import ump_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic selected;
  modport latch (output addr, output selected);
  modport core (input addr, input selected);
endinterface

// *** core/ump_select_latch.sv ***
`timescale 1ns/1ns
module ump_select_latch
  import ump_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // host select pins
  input wire logic [ump_pkg::ADDR_W-1:0] addr_in,
  input wire logic select_a_hi_in,
  input wire logic select_b_hi_in,
  input wire logic select_c_lo_in,
  input wire logic addr_latch_strobe_n_in,
  // decoded select
  ump_sel_if.latch sel
);
  import ump_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic selected;
  } ump_latch_t;

  ump_latch_t st;
  ump_latch_t next_st;
  logic live_sel;

  // while the strobe is low, any one inactive select deselects the device
  assign live_sel = select_a_hi_in & select_b_hi_in & ~select_c_lo_in;

  // ****************************************************************
  // strobe latch
  // ****************************************************************
  // held copy tracks the pins while the strobe is low, so at the rising
  // edge it keeps the last low-phase levels
  always_comb begin
    next_st = st;
    if (!addr_latch_strobe_n_in) begin
      next_st.addr = addr_in;
      next_st.selected = live_sel;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sel.addr = addr_latch_strobe_n_in ? st.addr : addr_in;
  assign sel.selected = addr_latch_strobe_n_in ? st.selected : live_sel;

  a_latch_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    addr_latch_strobe_n_in && $past(addr_latch_strobe_n_in)
    |-> $stable(sel.addr) && $stable(sel.selected))
    else $error("select latch changed while strobe high");

endmodule // ump_select_latch

// *** bench/ump_modem_model.sv ***
`timescale 1ns/1ns
// modem side; lines move only on the falling edge so they never race the sampling edge
module ump_modem_model (
  // clock
  input wire logic sys_clk_in,
  // commanded levels, index 0 cts 1 dsr 2 ri 3 dcd
  input wire logic [3:0] want_n_in,
  // modem lines
  output logic cts_n_out,
  output logic dsr_n_out,
  output logic ri_n_out,
  output logic dcd_n_out
);
  logic [3:0] lines_n = 4'hf;
  always @(negedge sys_clk_in) begin
    lines_n <= want_n_in;
  end
  assign {dcd_n_out, ri_n_out, dsr_n_out, cts_n_out} = lines_n;
endmodule // ump_modem_model

// *** bench/test_ump_pins.sv ***
`timescale 1ns/1ns
module test_ump_pins;
  import ump_pkg::*;
  localparam logic [2:0] SEL_ON = 3'h6;
  localparam logic [2:0] SEL_OFF = 3'h1;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, hard_clear_in = 1'b0;
  logic [2:0] addr_in = 3'h0, sel = SEL_OFF;
  logic addr_latch_strobe_n_in = 1'b0, rd_in = 1'b0, wr_in = 1'b0;
  logic msi_enable_in = 1'b0, rx_threshold_hit_in = 1'b0;
  logic [7:0] data_in = 8'h00, data_out, got, d;
  logic data_oe_out, xcvr_off_n_out, irq_out, tx_gate_out;
  logic [4:0] src = 5'h00;
  logic [3:0] want_n = 4'hf, exp_delta = 4'h0;
  wire cts_n_in, dsr_n_in, ri_n_in, dcd_n_in;
  wire select_a_hi_in, select_b_hi_in, select_c_lo_in;
  wire rx_error_in, rx_avail_in, rx_timeout_in, fifo_mode_in, thr_empty_in;
  logic dtr_n_out, rts_n_out, user_pin_a_n_out, user_pin_b_n_out;
  wire [3:0] outs_n = {user_pin_b_n_out, user_pin_a_n_out, rts_n_out, dtr_n_out};
  int bad_count = 0, compares = 0;
  assign {select_a_hi_in, select_b_hi_in, select_c_lo_in} = sel;
  assign {rx_error_in, rx_avail_in, rx_timeout_in, fifo_mode_in, thr_empty_in} = src;

  always #10 sys_clk_in = ~sys_clk_in;

  ump_pins uut (.sys_clk_in, .rst_n_in, .hard_clear_in, .addr_in, .select_a_hi_in,
    .select_b_hi_in, .select_c_lo_in, .addr_latch_strobe_n_in, .rd_in, .wr_in, .data_in,
    .data_out, .data_oe_out, .xcvr_off_n_out, .msi_enable_in, .rx_error_in, .rx_avail_in,
    .rx_timeout_in, .fifo_mode_in, .thr_empty_in, .irq_out, .rx_threshold_hit_in,
    .tx_gate_out, .cts_n_in, .dsr_n_in, .ri_n_in, .dcd_n_in, .dtr_n_out, .rts_n_out,
    .user_pin_a_n_out, .user_pin_b_n_out);
  ump_modem_model modem (.sys_clk_in, .want_n_in(want_n), .cts_n_out(cts_n_in),
    .dsr_n_out(dsr_n_in), .ri_n_out(ri_n_in), .dcd_n_out(dcd_n_in));

  function automatic logic [7:0] w(input logic x);
    return {7'h0, x};
  endfunction

  // ring flags only its trailing edge, the others any change
  function automatic logic [3:0] delta_of(input logic [3:0] was_n, input logic [3:0] now_n);
    logic [3:0] x;
    x = was_n ^ now_n;
    x[LN_RI] = ~was_n[LN_RI] & now_n[LN_RI];
    return x;
  endfunction

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // request held over two rising edges, then released at a falling edge
  task automatic bus(input logic wr, input logic [2:0] s, input logic [2:0] a,
                     input logic [7:0] v);
    @(negedge sys_clk_in);
    sel = s;
    addr_in = a;
    data_in = v;
    wr_in = wr;
    rd_in = ~wr;
    #1 check({6'h0, data_oe_out, xcvr_off_n_out}, {6'h0, {2{~wr & (s == SEL_ON)}}});
    repeat (2) @(negedge sys_clk_in);
    got = data_out;
    sel = SEL_OFF;
    wr_in = 1'b0;
    rd_in = 1'b0;
    #1 check({6'h0, data_oe_out, xcvr_off_n_out}, 8'h00);
    @(negedge sys_clk_in);
  endtask

  task automatic lines(input logic [3:0] n);
    exp_delta = exp_delta | delta_of(want_n, n);
    want_n = n;
    repeat (5) @(negedge sys_clk_in);
  endtask

  initial begin
    void'($urandom(72));
    repeat (3) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    check({3'h0, irq_out, outs_n}, 8'h0f);
    check(w(tx_gate_out), 8'h01);
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h0f : (8'($urandom) & 8'h0f);
      bus(1'b1, SEL_ON, ADDR_MCR, d);
      check({4'h0, outs_n}, {4'h0, ~d[3:0]});
    end
    bus(1'b1, SEL_ON, ADDR_MCR, 8'h1f);
    check({4'h0, outs_n}, 8'h0f);
    // loop mode feeds every control bit back as an active line level
    bus(1'b0, SEL_ON, ADDR_MSR, 8'h00);
    check({4'h0, got[7:4]}, 8'h0f);
    bus(1'b1, SEL_ON, ADDR_MCR, 8'h00);
    for (int s = 0; s < 8; s++) begin
      if (s != SEL_ON) begin
        bus(1'b1, 3'(s), ADDR_MCR, 8'h0f);
        check({4'h0, outs_n}, 8'h0f);
        bus(1'b0, 3'(s), ADDR_MSR, 8'h00);
        check(got, 8'h00);
      end
    end
    msi_enable_in = 1'b1;
    // loop mode left stale change flags behind
    bus(1'b0, SEL_ON, ADDR_MSR, 8'h00);
    exp_delta = 4'h0;
    for (int i = 0; i < 16; i++) begin
      lines((i < 8) ? want_n ^ (4'h1 << (i % 4)) : 4'($urandom));
      check(w(irq_out), w(|exp_delta));
      bus(1'b0, SEL_ON, ADDR_MSR, 8'h00);
      check(got, {~want_n, exp_delta});
      exp_delta = 4'h0;
      repeat (2) @(negedge sys_clk_in);
      check(w(irq_out), 8'h00);
    end
    bus(1'b1, SEL_ON, ADDR_MCR, 8'h22);
    for (int i = 0; i < 2; i++) begin
      lines(want_n ^ 4'h1);
      check(w(irq_out), 8'h00);
      check(w(tx_gate_out), w(~want_n[LN_CTS]));
      rx_threshold_hit_in = ~rx_threshold_hit_in;
      repeat (3) @(negedge sys_clk_in);
      check(w(rts_n_out), w(rx_threshold_hit_in));
    end
    lines(want_n ^ 4'h2);
    check(w(irq_out), 8'h01);
    bus(1'b1, SEL_ON, ADDR_MCR, 8'h0f);
    hard_clear_in = 1'b1;
    @(negedge sys_clk_in);
    hard_clear_in = 1'b0;
    @(negedge sys_clk_in);
    check({3'h0, irq_out, outs_n}, 8'h0f);
    bus(1'b0, SEL_ON, ADDR_MSR, 8'h00);
    check(got, {~want_n, 4'h0});
    msi_enable_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      src = (i == 5) ? 5'h06 : ((i < 5) ? 5'h10 >> i : 5'($urandom));
      repeat (2) @(negedge sys_clk_in);
      check(w(irq_out), w(src[4] | src[3] | (src[2] & src[1]) | src[0]));
      src = 5'h00;
      repeat (2) @(negedge sys_clk_in);
      check(w(irq_out), 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      sel = i[0] ? SEL_OFF : SEL_ON;
      @(negedge sys_clk_in);
      addr_latch_strobe_n_in = 1'b1;
      @(negedge sys_clk_in);
      sel = i[0] ? SEL_ON : SEL_OFF;
      rd_in = 1'b1;
      #1 check(w(data_oe_out), w(i == 0));
      @(negedge sys_clk_in);
      rd_in = 1'b0;
      sel = SEL_OFF;
      addr_latch_strobe_n_in = 1'b0;
    end
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge sys_clk_in);
    bad_count++;
    tally_and_finish();
  end
endmodule // test_ump_pins
